// File: logic/alu_link_if.sv
`default_nettype none
interface alu_link_if;
	import exec_pkg::*;
	alu_op_type  op;
	logic [15:0] a;
	logic [7:0]  b;
	logic        use_c;
	logic [7:0]  status_in;
	logic [15:0] result;
	logic [7:0]  status_out;

	modport ctrl (output op, a, b, use_c, status_in, input result, status_out);
	modport unit (input op, a, b, use_c, status_in, output result, status_out);
endinterface : alu_link_if
`default_nettype wire

// File: logic/cpu_arith_branch_exec.sv
`default_nettype none
module cpu_arith_branch_exec
	import exec_pkg::*;
#(
	parameter int PC_W  = 16,
	parameter int OFS_W = 12
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// Instruction request
	input  wire logic              start,
	input  wire op_type            op_in,
	input  wire logic [7:0]        rd_val,
	input  wire logic [7:0]        rd_hi_val,
	input  wire logic [7:0]        source_reg,
	input  wire logic [7:0]        imm_val,
	input  wire logic [7:0]        io_val,
	input  wire logic [2:0]        bit_sel,
	input  wire logic [OFS_W-1:0]  offset,
	input  wire logic [15:0]       pointer_pair,
	input  wire logic [PC_W-1:0]   pc_in,
	input  wire logic              next_two_word,
	// Status load from the rest of the core
	input  wire logic              status_wr,
	input  wire logic [7:0]        status_wdata,
	// Completion and results
	output logic                   busy,
	output logic                   done,
	output logic                   reg_wr,
	output logic [7:0]             reg_wdata,
	output logic                   word_wr,
	output logic [15:0]            word_wdata,
	output logic [PC_W-1:0]        pc_out,
	output logic                   push,
	output logic [PC_W-1:0]        push_addr,
	output logic [7:0]             status_flags
);
	// Widths the address arithmetic cannot serve are refused at elaboration
	if (PC_W < 2 || PC_W > 16) begin : g_bad_pc_w
		$error("PC_W out of range");
	end
	if (OFS_W < 2 || OFS_W > PC_W) begin : g_bad_ofs_w
		$error("OFS_W out of range");
	end

	// ****************************************
	// Decode
	// ****************************************
	alu_link_if alu_u ();
	exec_alu u_alu (.u(alu_u));

	logic [PC_W-1:0] rel_target;
	logic [PC_W-1:0] seq_pc;
	logic [PC_W-1:0] skip_pc;
	logic [PC_W-1:0] ptr_target;
	logic [1:0]      skip_cyc;
	logic            wr_nxt;
	logic            wword_nxt;
	logic            push_nxt;
	logic [1:0]      cyc_nxt;
	logic [PC_W-1:0] pc_nxt;

	// Offset is sign extended to the counter width
	assign rel_target = pc_in + PC_W'($signed(offset)) + PC_W'(1);
	assign seq_pc     = pc_in + PC_W'(1);
	assign skip_pc    = pc_in + (next_two_word ? PC_W'(3) : PC_W'(2));
	assign skip_cyc   = next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;
	assign ptr_target = pointer_pair[PC_W-1:0];

	// One decode case picks operands, write-back, timing and next address
	always_comb begin
		alu_u.op = alu_pass;
		alu_u.a = {8'h00, rd_val};
		alu_u.b = source_reg;
		alu_u.use_c = 1'b0;
		alu_u.status_in = status_flags;
		wr_nxt = 1'b1;
		wword_nxt = 1'b0;
		push_nxt = 1'b0;
		cyc_nxt = CYC_ONE;
		pc_nxt = seq_pc;
		case (op_in)
			op_sum_registers: alu_u.op = alu_add;
			op_sum_with_carry_in: begin
				alu_u.op = alu_add;
				alu_u.use_c = 1'b1;
			end
			op_word_sum_immediate, op_word_difference_immediate: begin
				alu_u.op = (op_in == op_word_sum_immediate) ? alu_word_add : alu_word_sub;
				alu_u.a = {rd_hi_val, rd_val};
				alu_u.b = imm_val;
				wr_nxt = 1'b0;
				wword_nxt = 1'b1;
				cyc_nxt = CYC_WORD;
			end
			op_difference_registers: alu_u.op = alu_sub;
			op_difference_immediate: begin
				alu_u.op = alu_sub;
				alu_u.b = imm_val;
			end
			op_difference_with_borrow, op_difference_immediate_with_borrow: begin
				alu_u.op = alu_sub;
				alu_u.use_c = 1'b1;
				if (op_in == op_difference_immediate_with_borrow)
					alu_u.b = imm_val;
			end
			op_conjunction: alu_u.op = alu_and;
			op_disjunction: alu_u.op = alu_or;
			op_exclusive_disjunction: alu_u.op = alu_xor;
			op_conjunction_immediate: begin
				alu_u.op = alu_and;
				alu_u.b = imm_val;
			end
			op_disjunction_immediate, op_bits_set_mask: begin
				alu_u.op = alu_or;
				alu_u.b = imm_val;
			end
			op_bits_clear_mask: begin
				alu_u.op = alu_and;
				alu_u.b = ALL_ONES - imm_val;
			end
			op_bit_invert: alu_u.op = alu_com;
			op_arith_minus: begin
				alu_u.op = alu_sub;
				alu_u.a = {8'h00, ALL_ZEROS};
				alu_u.b = rd_val;
			end
			op_plus_one: alu_u.op = alu_inc;
			op_minus_one: alu_u.op = alu_dec;
			op_zero_sign_probe: begin
				alu_u.op = alu_and;
				alu_u.b = rd_val;
			end
			op_zero_register: begin
				alu_u.op = alu_xor;
				alu_u.b = rd_val;
			end
			op_all_ones_load: alu_u.b = ALL_ONES;
			op_flag_compare, op_carry_compare, op_immediate_compare: begin
				alu_u.op = alu_sub;
				alu_u.use_c = (op_in == op_carry_compare);
				if (op_in == op_immediate_compare)
					alu_u.b = imm_val;
				wr_nxt = 1'b0;
			end
			op_relative_goto, op_pointer_goto: begin
				wr_nxt = 1'b0;
				cyc_nxt = CYC_JUMP;
				pc_nxt = (op_in == op_relative_goto) ? rel_target : ptr_target;
			end
			op_relative_subroutine_entry, op_pointer_subroutine_entry: begin
				wr_nxt = 1'b0;
				push_nxt = 1'b1;
				cyc_nxt = CYC_CALL;
				pc_nxt = (op_in == op_relative_subroutine_entry) ? rel_target : ptr_target;
			end
			op_equal_skip, op_skip_reg_bit_low, op_skip_reg_bit_high,
			op_skip_io_bit_low, op_skip_io_bit_high: begin
				wr_nxt = 1'b0;
				// Skip taken: step over one or two words
				if ((op_in == op_equal_skip && rd_val == source_reg) ||
				    (op_in == op_skip_reg_bit_low && !source_reg[bit_sel]) ||
				    (op_in == op_skip_reg_bit_high && source_reg[bit_sel]) ||
				    (op_in == op_skip_io_bit_low && !io_val[bit_sel]) ||
				    (op_in == op_skip_io_bit_high && io_val[bit_sel])) begin
					cyc_nxt = skip_cyc;
					pc_nxt = skip_pc;
				end
			end
			op_branch_flag_high, op_branch_flag_low, op_branch_zero_flag: begin
				wr_nxt = 1'b0;
				// Taken branch costs the extra clock
				if ((op_in == op_branch_flag_high && status_flags[bit_sel]) ||
				    (op_in == op_branch_flag_low && !status_flags[bit_sel]) ||
				    (op_in == op_branch_zero_flag && status_flags[FLAG_Z])) begin
					cyc_nxt = CYC_BR_TAKEN;
					pc_nxt = rel_target;
				end
			end
			default: wr_nxt = 1'b0;
		endcase
	end

	// ****************************************
	// Sequencing
	// ****************************************
	state_type  state_r;
	logic [1:0] cnt_r;
	logic       wr_p_r;
	logic       wword_p_r;
	logic       push_p_r;
	logic [7:0] status_p_r;
	logic       finish;
	logic       accept;

	assign accept = start && state_r == st_idle;
	assign finish = state_r == st_wait && cnt_r == 2'h0;

	// Requests arriving while busy are ignored
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= st_idle;
			cnt_r <= 2'h0;
		end else begin
			case (state_r)
				st_idle: if (accept && cyc_nxt != CYC_ONE) begin
					state_r <= st_wait;
					cnt_r <= cyc_nxt - 2'h2;
				end
				st_wait: if (cnt_r == 2'h0)
					state_r <= st_idle;
				else
					cnt_r <= cnt_r - 2'h1;
				default: state_r <= st_idle;
			endcase
		end
	end

	// Results latched at acceptance, valid while done is high
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_wdata <= 8'h00;
			word_wdata <= 16'h0000;
			pc_out <= '0;
			push_addr <= '0;
			wr_p_r <= 1'b0;
			wword_p_r <= 1'b0;
			push_p_r <= 1'b0;
			status_p_r <= STATUS_RST;
		end else if (accept) begin
			reg_wdata <= alu_u.result[7:0];
			word_wdata <= alu_u.result;
			pc_out <= pc_nxt;
			push_addr <= seq_pc; // Return lands after this instruction
			wr_p_r <= wr_nxt;
			wword_p_r <= wword_nxt;
			push_p_r <= push_nxt;
			status_p_r <= alu_u.status_out;
		end
	end

	// Completion pulses; single-clock work finishes on the accept edge
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			done <= 1'b0;
			reg_wr <= 1'b0;
			word_wr <= 1'b0;
			push <= 1'b0;
			busy <= 1'b0;
		end else begin
			done <= (accept && cyc_nxt == CYC_ONE) || finish;
			reg_wr <= (accept && cyc_nxt == CYC_ONE) ? wr_nxt : finish && wr_p_r;
			word_wr <= finish && wword_p_r;
			push <= finish && push_p_r;
			busy <= (accept && cyc_nxt != CYC_ONE) || (state_r == st_wait && !finish);
		end
	end

	// Flags commit with completion; an outside write yields to a finishing op
	always_ff @(posedge clock) begin
		if (sys_rst)
			status_flags <= STATUS_RST;
		else if (accept && cyc_nxt == CYC_ONE)
			status_flags <= alu_u.status_out;
		else if (finish)
			status_flags <= status_p_r;
		else if (status_wr)
			status_flags <= status_wdata;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	add_one_clock_a: assert property (
		accept && op_in == op_sum_registers |=> done && reg_wr &&
			reg_wdata == $past(rd_val) + $past(source_reg))
		else $error("add did not finish in one clock");
	word_two_clock_a: assert property (
		accept && op_in == op_word_sum_immediate |=> !done ##1 done && word_wr)
		else $error("word op not two clocks");
	logic_clears_v_a: assert property (
		accept && op_in == op_conjunction |=> !status_flags[FLAG_V] &&
			status_flags[FLAG_C] == $past(status_flags[FLAG_C]))
		else $error("logic op flag update wrong");
	ones_keeps_flags_a: assert property (
		accept && op_in == op_all_ones_load |=> reg_wdata == ALL_ONES &&
			status_flags == $past(status_flags))
		else $error("all ones load wrong");
	goto_target_a: assert property (
		accept && op_in == op_relative_goto && !status_wr |-> ##2 done &&
			pc_out == $past(rel_target, 2) && status_flags == $past(status_flags, 2))
		else $error("relative goto wrong");
	call_push_a: assert property (
		accept && op_in == op_pointer_subroutine_entry |=> !done [*2] ##1
			(done && push && push_addr == $past(seq_pc, 3)))
		else $error("subroutine entry wrong");
	compare_no_write_a: assert property (
		accept && op_in == op_flag_compare |=> done && !reg_wr &&
			status_flags[FLAG_Z] == ($past(rd_val) == $past(source_reg)))
		else $error("compare wrong");
	skip_two_word_a: assert property (
		accept && op_in == op_equal_skip && rd_val == source_reg && next_two_word
			|=> !done [*2] ##1 (done && pc_out == $past(pc_in, 3) + PC_W'(3)))
		else $error("two-word skip wrong");
	branch_not_taken_a: assert property (
		accept && op_in == op_branch_zero_flag && !status_flags[FLAG_Z]
			|=> done && pc_out == $past(seq_pc))
		else $error("untaken branch wrong");
endmodule : cpu_arith_branch_exec
`default_nettype wire

// File: logic/exec_alu.sv
`default_nettype none
module exec_alu
	import exec_pkg::*;
(
	alu_link_if.unit u
);
	// ****************************************
	// Result and flag computation
	// ****************************************
	// Untouched flags pass through from the current status
	always_comb begin
		logic [8:0]  sum;
		logic [16:0] w;
		logic [7:0]  a8;
		logic [7:0]  r8;
		logic        cin;
		logic        h;
		logic        v;
		logic        c;
		logic        zc;
		sum = 9'h000;
		w = 17'h00000;
		a8 = u.a[7:0];
		r8 = 8'h00;
		cin = u.use_c & u.status_in[FLAG_C];
		h = u.status_in[FLAG_H];
		v = 1'b0;
		c = u.status_in[FLAG_C];
		// Only the borrow chain keeps Z sticky-low; add-with-carry sets Z afresh
		zc = (u.use_c && u.op == alu_sub) ? u.status_in[FLAG_Z] : 1'b1;
		u.status_out = u.status_in;
		u.result = 16'h0000;
		case (u.op)
			alu_add: begin
				sum = {1'b0, a8} + {1'b0, u.b} + {8'h00, cin};
				r8 = sum[7:0];
				c = sum[8];
				h = (a8[3] & u.b[3]) | (u.b[3] & ~r8[3]) | (~r8[3] & a8[3]);
				v = (a8[7] & u.b[7] & ~r8[7]) | (~a8[7] & ~u.b[7] & r8[7]);
			end
			alu_sub: begin
				sum = {1'b0, a8} - {1'b0, u.b} - {8'h00, cin};
				r8 = sum[7:0];
				c = sum[8];
				h = (~a8[3] & u.b[3]) | (u.b[3] & r8[3]) | (r8[3] & ~a8[3]);
				v = (a8[7] & ~u.b[7] & ~r8[7]) | (~a8[7] & u.b[7] & r8[7]);
			end
			alu_and: r8 = a8 & u.b;
			alu_or:  r8 = a8 | u.b;
			alu_xor: r8 = a8 ^ u.b;
			alu_com: begin
				r8 = ALL_ONES - a8;
				c = 1'b1;
			end
			alu_inc: begin
				r8 = a8 + 8'h01;
				v = (r8 == 8'h80);
			end
			alu_dec: begin
				r8 = a8 - 8'h01;
				v = (r8 == 8'h7f);
			end
			alu_word_add: begin
				w = {1'b0, u.a} + {11'h000, u.b[WORD_IMM_W-1:0]};
				v = ~u.a[15] & w[15];
				c = ~w[15] & u.a[15];
			end
			alu_word_sub: begin
				w = {1'b0, u.a} - {11'h000, u.b[WORD_IMM_W-1:0]};
				v = u.a[15] & ~w[15];
				c = w[15] & ~u.a[15];
			end
			default: r8 = u.b;
		endcase
		if (u.op == alu_word_add || u.op == alu_word_sub) begin
			u.result = w[15:0];
			u.status_out[FLAG_Z] = (w[15:0] == 16'h0000);
			u.status_out[FLAG_N] = w[15];
		end else begin
			u.result = {8'h00, r8};
			u.status_out[FLAG_Z] = (r8 == ALL_ZEROS) & zc;
			u.status_out[FLAG_N] = r8[7];
		end
		if (u.op != alu_pass) begin
			u.status_out[FLAG_V] = v;
			u.status_out[FLAG_S] = u.status_out[FLAG_N] ^ v;
			u.status_out[FLAG_C] = c;
			u.status_out[FLAG_H] = h;
		end else begin
			u.status_out = u.status_in;
		end
	end
endmodule : exec_alu
`default_nettype wire

// File: logic/exec_pkg.sv
`default_nettype none
package exec_pkg;
	// ****************************************
	// Status flag bit positions
	// ****************************************
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	localparam logic [7:0] STATUS_RST  = 8'h00;
	localparam logic [7:0] ALL_ONES    = 8'hff;
	localparam logic [7:0] ALL_ZEROS   = 8'h00;
	localparam int         WORD_IMM_W  = 6;

	// ****************************************
	// Cycle counts per instruction class
	// ****************************************
	localparam logic [1:0] CYC_ONE       = 2'h1;
	localparam logic [1:0] CYC_WORD      = 2'h2;
	localparam logic [1:0] CYC_JUMP      = 2'h2;
	localparam logic [1:0] CYC_CALL      = 2'h3;
	localparam logic [1:0] CYC_SKIP_ONE  = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO  = 2'h3;
	localparam logic [1:0] CYC_BR_TAKEN  = 2'h2;

	// Instructions handed to the executor
	typedef enum logic [5:0] {
		op_sum_registers, op_sum_with_carry_in, op_word_sum_immediate,
		op_difference_registers, op_difference_immediate,
		op_difference_with_borrow, op_difference_immediate_with_borrow,
		op_word_difference_immediate, op_conjunction, op_conjunction_immediate,
		op_disjunction, op_disjunction_immediate, op_exclusive_disjunction,
		op_bit_invert, op_arith_minus, op_bits_set_mask, op_bits_clear_mask,
		op_plus_one, op_minus_one, op_zero_sign_probe, op_zero_register,
		op_all_ones_load, op_relative_goto, op_pointer_goto,
		op_relative_subroutine_entry, op_pointer_subroutine_entry,
		op_equal_skip, op_flag_compare, op_carry_compare, op_immediate_compare,
		op_skip_reg_bit_low, op_skip_reg_bit_high, op_skip_io_bit_low,
		op_skip_io_bit_high, op_branch_flag_high, op_branch_flag_low,
		op_branch_zero_flag
	} op_type;

	// Operations of the arithmetic unit
	typedef enum logic [3:0] {
		alu_add, alu_sub, alu_and, alu_or, alu_xor, alu_com, alu_inc, alu_dec,
		alu_word_add, alu_word_sub, alu_pass
	} alu_op_type;

	typedef enum logic [0:0] {
		st_idle, st_wait
	} state_type;
endpackage : exec_pkg
`default_nettype wire

// File: testbench/regfile_model.sv
`default_nettype none
// ******************************
// Register file seen by the core
// ******************************
module regfile_model (
	// Clock
	input  wire logic        clock,
	// Operand load from the bench
	input  wire logic        ld,
	input  wire logic [23:0] ld_val,
	// Write-back from the executor
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        word_wr,
	input  wire logic [15:0] word_wdata,
	// Operands
	output logic      [7:0]  rd_val,
	output logic      [7:0]  rd_hi_val,
	output logic      [7:0]  source_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	// Known operands from time zero, before the first load
	initial begin
		{rd_hi_val, rd_val, source_reg} = 24'h000000;
	end
	// Load wins over write-back, so every test starts from the operands it chose
	always @(posedge clock) begin
		if (ld)
			{rd_hi_val, rd_val, source_reg} <= ld_val;
		else if (word_wr)
			{rd_hi_val, rd_val} <= word_wdata; // High byte first
		else if (reg_wr)
			rd_val <= reg_wdata;
	end
endmodule : regfile_model
`default_nettype wire

// File: testbench/testbench.sv
`default_nettype none
`define CHK(nm, x_exp, x_got) \
	begin \
		n_tests++; \
		if ((x_got) !== (x_exp)) begin \
			n_errors++; \
			$display("BAD %s exp %h got %h", nm, x_exp, x_got); \
		end \
	end
module testbench
	import exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [15:0] r;
		logic [7:0]  s;
		logic [1:0]  wk;
		logic [15:0] pc;
		logic [15:0] pa;
		logic        fl;
		logic        ps;
		int          n;
	} note_type;
	logic        clock, sys_rst, start, next_two_word, status_wr, ld;
	op_type      op_in;
	logic [7:0]  rd_val, rd_hi_val, source_reg, imm_val, io_val, status_wdata;
	logic [2:0]  bit_sel;
	logic [11:0] offset;
	logic [15:0] pointer_pair, pc_in;
	logic [23:0] ld_val;
	logic        busy, done, reg_wr, word_wr, push;
	logic [7:0]  reg_wdata, status_flags;
	logic [15:0] word_wdata, pc_out, push_addr;
	int          n_errors, n_tests, cyc, tk;
	note_type    q[$];
	note_type    nt;
	int          takes[$];

	cpu_arith_branch_exec #(.PC_W(16), .OFS_W(12)) i_dut (.clock(clock), .sys_rst(sys_rst),
		.start(start), .op_in(op_in), .rd_val(rd_val), .rd_hi_val(rd_hi_val),
		.source_reg(source_reg), .imm_val(imm_val), .io_val(io_val), .bit_sel(bit_sel),
		.offset(offset), .pointer_pair(pointer_pair), .pc_in(pc_in),
		.next_two_word(next_two_word), .status_wr(status_wr), .status_wdata(status_wdata),
		.busy(busy), .done(done), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .word_wr(word_wr),
		.word_wdata(word_wdata), .pc_out(pc_out), .push(push), .push_addr(push_addr),
		.status_flags(status_flags));
	regfile_model i_regs (.clock(clock), .ld(ld), .ld_val(ld_val), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .word_wr(word_wr), .word_wdata(word_wdata), .rd_val(rd_val),
		.rd_hi_val(rd_hi_val), .source_reg(source_reg));

	// ******************************
	// Reference for data ops
	// ******************************
	// Mode m: 0 no flags, 1 add, 2 subtract, 3 logic, 4 word add, 5 word subtract
	function automatic void model(input op_type op, input logic [7:0] a, h, b, k, s,
			output logic [15:0] r, output logic [7:0] ns, output logic [1:0] wk);
		logic [8:0]  t;
		logic [4:0]  hn;
		logic [16:0] w;
		logic [7:0]  x, y;
		logic        ci, zk, v;
		int          m;
		ci = 1'b0;
		zk = 1'b0;
		v = 1'b0;
		x = a;
		y = b;
		m = 3;
		wk = 2'h1;
		ns = s;
		t = 9'h000;
		hn = 5'h00;
		case (op)
			op_sum_registers: m = 1;
			op_sum_with_carry_in: begin
				m = 1;
				ci = s[FLAG_C];
			end
			op_difference_registers, op_flag_compare: m = 2;
			op_difference_immediate, op_immediate_compare: begin
				m = 2;
				y = k;
			end
			op_difference_with_borrow, op_carry_compare, op_difference_immediate_with_borrow: begin
				m = 2;
				ci = s[FLAG_C];
				zk = 1'b1;
				if (op == op_difference_immediate_with_borrow)
					y = k;
			end
			op_arith_minus: begin
				m = 2;
				x = 8'h00;
				y = a;
			end
			op_conjunction: t = a & b;
			op_conjunction_immediate: t = a & k;
			op_disjunction: t = a | b;
			op_disjunction_immediate, op_bits_set_mask: t = a | k;
			op_bits_clear_mask: t = a & (8'hff - k);
			op_exclusive_disjunction: t = a ^ b;
			op_zero_sign_probe: t = a & a;
			op_zero_register: t = a ^ a;
			op_bit_invert: begin
				t = 8'hff - a;
				ns[FLAG_C] = 1'b1;
			end
			op_plus_one: begin
				t = a + 8'h01;
				v = (a == 8'h7f);
			end
			op_minus_one: begin
				t = a - 8'h01;
				v = (a == 8'h80);
			end
			op_all_ones_load: begin
				m = 0;
				t = 9'h0ff;
			end
			op_word_sum_immediate: m = 4;
			op_word_difference_immediate: m = 5;
			default: begin
				m = 0;
				wk = 2'h0;
			end
		endcase
		if (op inside {op_flag_compare, op_carry_compare, op_immediate_compare})
			wk = 2'h0; // Compares keep the register
		if (m == 1) begin
			t = x + y + ci;
			hn = x[3:0] + y[3:0] + ci;
			v = (x[7] & y[7] & ~t[7]) | (~x[7] & ~y[7] & t[7]);
		end
		if (m == 2) begin
			t = {1'b0, x} - y - ci;
			hn = {1'b0, x[3:0]} - y[3:0] - ci;
			v = (x[7] & ~y[7] & ~t[7]) | (~x[7] & y[7] & t[7]);
		end
		if (m == 1 || m == 2) begin
			ns[FLAG_C] = t[8];
			ns[FLAG_H] = hn[4];
		end
		r = {8'h00, t[7:0]};
		if (m >= 4) begin
			w = (m == 4) ? {1'b0, h, a} + k[5:0] : {1'b0, h, a} - k[5:0];
			r = w[15:0];
			wk = 2'h2;
			v = (m == 4) ? (~h[7] & w[15]) : (h[7] & ~w[15]);
			ns[FLAG_C] = w[16];
			ns[FLAG_Z] = (w[15:0] == 16'h0000);
			ns[FLAG_N] = w[15];
		end else if (m != 0) begin
			ns[FLAG_Z] = (t[7:0] == 8'h00) & (~zk | s[FLAG_Z]); // Borrow forms keep Z
			ns[FLAG_N] = t[7];
		end
		if (m != 0) begin
			ns[FLAG_V] = v;
			ns[FLAG_S] = ns[FLAG_N] ^ v;
		end
	endfunction : model

	// ******************************
	// Driver
	// ******************************
	// Word, goto and subroutine-entry ops hold start one extra cycle, which the busy core must ignore
	task automatic run(input op_type op);
		note_type    e;
		logic [7:0]  a, h, b, k, io, s;
		logic [15:0] pc, pp, rel;
		logic [11:0] of;
		logic [2:0]  bs;
		logic        tw, c, hold;
		int          i;
		{a, h, b, k} = $urandom;
		{io, s, bs, tw} = 20'($urandom);
		{pc, pp} = $urandom;
		of = 12'($urandom);
		if ($urandom % 2)
			b = a;
		model(op, a, h, b, k, s, e.r, e.s, e.wk);
		rel = pc + {{4{of[11]}}, of} + 16'h0001;
		e.n = (e.wk == 2'h2) ? 2 : 1;
		e.fl = 1'b1;
		e.ps = 1'b0;
		e.pa = pc + 16'h0001;
		c = 1'b0;
		case (op)
			op_relative_goto, op_pointer_goto: begin
				e.n = 2;
				e.pc = (op == op_relative_goto) ? rel : pp;
			end
			op_relative_subroutine_entry, op_pointer_subroutine_entry: begin
				e.n = 3;
				e.pc = (op == op_relative_subroutine_entry) ? rel : pp;
				e.ps = 1'b1;
			end
			op_equal_skip, op_skip_reg_bit_low, op_skip_reg_bit_high, op_skip_io_bit_low,
			op_skip_io_bit_high: begin
				case (op)
					op_equal_skip: c = (a == b);
					op_skip_reg_bit_low: c = ~b[bs];
					op_skip_reg_bit_high: c = b[bs];
					op_skip_io_bit_low: c = ~io[bs];
					default: c = io[bs];
				endcase
				e.n = c ? (tw ? 3 : 2) : 1;
				e.pc = pc + 16'(e.n);
			end
			op_branch_flag_high, op_branch_flag_low, op_branch_zero_flag: begin
				c = (op == op_branch_flag_high) ? s[bs] :
					(op == op_branch_flag_low) ? ~s[bs] : s[FLAG_Z];
				e.n = c ? 2 : 1;
				e.pc = c ? rel : e.pa;
			end
			default: e.fl = 1'b0;
		endcase
		hold = e.ps | (e.wk == 2'h2) | (op == op_relative_goto) | (op == op_pointer_goto);
		@(posedge clock);
		ld <= 1'b1;
		ld_val <= {h, a, b};
		status_wr <= 1'b1;
		status_wdata <= s;
		@(posedge clock);
		ld <= 1'b0;
		status_wr <= 1'b0;
		start <= 1'b1;
		op_in <= op;
		imm_val <= k;
		io_val <= io;
		bit_sel <= bs;
		offset <= of;
		pointer_pair <= pp;
		pc_in <= pc;
		next_two_word <= tw;
		q.push_back(e);
		@(posedge clock);
		if (hold)
			@(posedge clock);
		start <= 1'b0;
		i = 0;
		@(negedge clock);
		`CHK("busy", (e.n - int'(hold)) > 1, busy)
		while (done !== 1'b1 && ++i < 8)
			@(negedge clock);
		`CHK("done", 1'b1, done)
	endtask : run

	// ******************************
	// Monitor
	// ******************************
	// Latency is counted from the edge that took the request
	always @(posedge clock) begin
		if (start === 1'b1 && busy === 1'b0 && sys_rst === 1'b0)
			takes.push_back(cyc);
		if (done === 1'b1) begin
			if (q.size() == 0 || takes.size() == 0) begin
				n_errors++;
				$display("BAD done exp 0 got 1");
			end else begin
				nt = q.pop_front();
				tk = takes.pop_front();
				`CHK("cycles", nt.n, cyc - tk)
				`CHK("busy at done", 1'b0, busy)
				`CHK("status", nt.s, status_flags)
				`CHK("reg_wr", nt.wk == 2'h1, reg_wr)
				`CHK("word_wr", nt.wk == 2'h2, word_wr)
				`CHK("push", nt.ps, push)
				if (nt.wk == 2'h1)
					`CHK("reg_wdata", nt.r[7:0], reg_wdata)
				if (nt.wk == 2'h2)
					`CHK("word_wdata", nt.r, word_wdata)
				if (nt.fl)
					`CHK("pc_out", nt.pc, pc_out)
				if (nt.ps)
					`CHK("push_addr", nt.pa, push_addr)
			end
		end
		cyc++;
	end

	// ******************************
	// Clock, reset and sequence
	// ******************************
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic results();
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#50000;
		n_errors++;
		results();
	end

	initial begin
		{sys_rst, start, next_two_word, status_wr, ld} = 5'h10;
		op_in = op_sum_registers;
		{imm_val, io_val, status_wdata, bit_sel, offset} = 39'h0;
		{pointer_pair, pc_in, ld_val} = 56'h0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		`CHK("status after reset", STATUS_RST, status_flags)
		void'($urandom(32'h4302c356));
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i <= int'(op_branch_zero_flag); i++)
				run(op_type'(i));
		end
		repeat (4) @(posedge clock);
		results();
	end
endmodule : testbench
`default_nettype wire
